// ==== core/elj_seq.sv ====
// effect timeline sequencer with three programmable jumps/loops
// assumes i_step is an asynchronous timeline tick pin; registers over Avalon-MM
//
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module elj_seq (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_step,
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output logic [15:0] o_time,
  output logic o_done
);
  logic [3:0] ctrl_q;
  logic [15:0] end_q, wcnt_q, pass_q, time_q;
  logic [15:0] from_q [elj_pkg::NJ];
  logic [15:0] to_q [elj_pkg::NJ];
  logic [15:0] rep_q [elj_pkg::NJ];
  logic [15:0] rem_q [elj_pkg::NJ];
  logic [elj_pkg::NJ-1:0] jen_q, jcont_q;
  logic done_q, wait_q, stp_m_q, stp_s_q, stp_d_q;
  logic [31:0] rd_d;
  logic wr_go, start, step_go, hit, lp, at_end, whole_ok;
  logic [1:0] hj;
  logic [15:0] tgt, start_t;
  logic rev;

  assign rev = ctrl_q[elj_pkg::C_REV];

  // source and target exchange roles when running in reverse
  function automatic logic [15:0] src(input int j);
    return rev ? to_q[j] : from_q[j]; // see R9
  endfunction
  function automatic logic [15:0] dst(input int j);
    return rev ? from_q[j] : to_q[j]; // see R9
  endfunction
  function automatic logic is_loop(input int j);
    return rev ? (dst(j) > src(j)) : (dst(j) < src(j));
  endfunction
  function automatic logic [15:0] lo(input int j);
    return (from_q[j] < to_q[j]) ? from_q[j] : to_q[j];
  endfunction
  function automatic logic [15:0] hi(input int j);
    return (from_q[j] < to_q[j]) ? to_q[j] : from_q[j];
  endfunction
  // j lies wholly inside k; staggered spans are not contained
  function automatic logic inside_of(input int j, input int k);
    return (j != k) && (lo(j) >= lo(k)) && (hi(j) <= hi(k));
  endfunction

  // step pin synchroniser; only the second stage feeds the edge detect
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      stp_m_q <= 1'b0;
      stp_s_q <= 1'b0;
      stp_d_q <= 1'b0;
    end else begin
      stp_m_q <= i_step;
      stp_s_q <= stp_m_q;
      stp_d_q <= stp_s_q;
    end
  end

  assign wr_go = i_write && !wait_q;
  assign start = wr_go && (i_address == elj_pkg::A_CTRL) && i_writedata[elj_pkg::C_START];
  assign step_go = stp_s_q && !stp_d_q && ctrl_q[elj_pkg::C_RUN] && !done_q && !start;

  always_comb begin
    hit = 1'b0;
    hj = 2'h0;
    for (int j = elj_pkg::NJ - 1; j >= 0; j--) begin
      // lowest index wins when several sources coincide
      if (jen_q[j] && time_q == src(j) &&
          (!is_loop(j) || jcont_q[j] || rem_q[j] != 16'h0000)) begin
        hit = 1'b1; // see R5 see R10
        hj = j[1:0];
      end
    end
    // kept in the process: a continuous assign misses changes read inside functions
    tgt = dst(int'(hj));
    lp = is_loop(int'(hj));
  end
  assign start_t = rev ? end_q : 16'h0000;
  assign at_end = time_q == (rev ? 16'h0000 : end_q);
  assign whole_ok = ctrl_q[elj_pkg::C_WLOOP] &&
                    (ctrl_q[elj_pkg::C_WCONT] ? (pass_q < elj_pkg::PASS_MAX) : (pass_q < wcnt_q));

  // timeline position, pass count and done
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      time_q <= elj_pkg::TIME_RST;
      pass_q <= 16'h0000;
      done_q <= 1'b0;
    end else if (start) begin
      time_q <= i_writedata[elj_pkg::C_REV] ? end_q : 16'h0000;
      pass_q <= 16'h0000;
      done_q <= 1'b0;
    end else if (step_go) begin
      if (hit) begin
        time_q <= tgt; // see R2 see R4 see R10
      end else if (at_end) begin
        if (whole_ok) begin
          time_q <= start_t; // see R1
          pass_q <= pass_q + 16'h0001;
        end else begin
          done_q <= 1'b1;
        end
      end else begin
        time_q <= rev ? time_q - 16'h0001 : time_q + 16'h0001; // see R3
      end
    end
  end

  // repeat counters
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int j = 0; j < elj_pkg::NJ; j++) begin
        rem_q[j] <= 16'h0000;
      end
    end else begin
      for (int j = 0; j < elj_pkg::NJ; j++) begin
        if (start || (wr_go && i_address == elj_pkg::A_JBASE + 8'(j * 16) + 8'h08)) begin
          rem_q[j] <= (start ? rep_q[j] : i_writedata[15:0]);
        end else if (step_go && hit) begin
          if (j == int'(hj) && lp && !jcont_q[j]) begin
            rem_q[j] <= rem_q[j] - 16'h0001; // see R3 see R10
          end else if (inside_of(j, int'(hj)) && lp) begin
            // outer loop goes round again: inner loop runs fully anew
            rem_q[j] <= rep_q[j]; // see R6 see R7
          end
          // overlapping spans fall through untouched, or they never end
          // see R8
        end else if (step_go && at_end && whole_ok) begin
          rem_q[j] <= rep_q[j]; // see R6
        end
      end
    end
  end

  // software-written settings
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_q <= elj_pkg::CTRL_RST;
      end_q <= 16'h0000;
      wcnt_q <= 16'h0000;
      jen_q <= '0;
      jcont_q <= '0;
      for (int j = 0; j < elj_pkg::NJ; j++) begin
        from_q[j] <= 16'h0000;
        to_q[j] <= 16'h0000;
        rep_q[j] <= 16'h0000;
      end
    end else if (wr_go) begin
      case (i_address)
        elj_pkg::A_CTRL: ctrl_q <= i_writedata[3:0];
        elj_pkg::A_END: end_q <= i_writedata[15:0];
        elj_pkg::A_WCNT: wcnt_q <= i_writedata[15:0];
        default: begin
          for (int j = 0; j < elj_pkg::NJ; j++) begin
            if (i_address[7:4] == 4'(j + 2) && i_address[1:0] == 2'h0) begin
              case (i_address[3:2])
                elj_pkg::J_FROM: from_q[j] <= i_writedata[15:0];
                elj_pkg::J_TO: to_q[j] <= i_writedata[15:0];
                elj_pkg::J_CFG: begin
                  rep_q[j] <= i_writedata[15:0];
                  jen_q[j] <= i_writedata[elj_pkg::G_EN];
                  jcont_q[j] <= i_writedata[elj_pkg::G_CONT];
                end
                default: ;
              endcase
            end
          end
        end
      endcase
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_d = 32'h0000_0000;
    case (i_address)
      elj_pkg::A_CTRL: rd_d = {28'h0, ctrl_q};
      elj_pkg::A_END: rd_d = {16'h0, end_q};
      elj_pkg::A_WCNT: rd_d = {16'h0, wcnt_q};
      elj_pkg::A_TIME: rd_d = {16'h0, time_q};
      elj_pkg::A_STAT: rd_d = {pass_q, 15'h0, done_q};
      default: begin
        for (int j = 0; j < elj_pkg::NJ; j++) begin
          if (i_address[7:4] == 4'(j + 2) && i_address[1:0] == 2'h0) begin
            case (i_address[3:2])
              elj_pkg::J_FROM: rd_d = {16'h0, from_q[j]};
              elj_pkg::J_TO: rd_d = {16'h0, to_q[j]};
              elj_pkg::J_CFG: rd_d = {14'h0, jcont_q[j], jen_q[j], rep_q[j]};
              default: rd_d = {16'h0, rem_q[j]};
            endcase
          end
        end
      end
    endcase
  end

  // one wait cycle per access; data registered alongside the release
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wait_q <= 1'b1;
      o_readdata <= 32'h0000_0000;
    end else begin
      wait_q <= !((i_read || i_write) && wait_q);
      if (i_read && wait_q) begin
        o_readdata <= rd_d;
      end
    end
  end

  assign o_waitrequest = wait_q;
  assign o_time = time_q;
  assign o_done = done_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  loop_jump_a: assert property (step_go && hit && lp |=> time_q == $past(tgt)) // see R2
    else $error("loop jump did not land on target");
  skip_jump_a: assert property (step_go && hit && !lp |=> time_q == $past(tgt)) // see R4
    else $error("skip jump did not land on target");
  run_past_a: assert property (step_go && !hit && !at_end && !rev |=> // see R3
    time_q == $past(time_q) + 16'h0001)
    else $error("timeline did not advance past source");
  whole_wrap_a: assert property (step_go && !hit && at_end && whole_ok |=> // see R1
    time_q == $past(start_t))
    else $error("whole effect did not wrap to start");
  pass_cap_a: assert property (pass_q <= elj_pkg::PASS_MAX) // see R1
    else $error("pass count above cap");
  reverse_swap_a: assert property (rev && hit |-> tgt == from_q[hj]) // see R9
    else $error("reverse target is not the source time");
  inner_reload_a: assert property (step_go && hit && lp && inside_of(1, int'(hj)) && !wr_go |=> // see R7
    rem_q[1] == rep_q[1])
    else $error("contained loop counter not reloaded");
  overlap_keep_a: assert property (step_go && hit && hj != 2'h1 && // see R8
    !inside_of(1, int'(hj)) && !wr_go |=> $stable(rem_q[1]))
    else $error("overlapping loop counter changed");
  idle_hold_a: assert property (!step_go && !start |=> $stable(time_q)) // see R10
    else $error("time moved without a step");
  loop_taken_c: cover property (step_go && hit && lp);
  skip_taken_c: cover property (step_go && hit && !lp);
  wrap_taken_c: cover property (step_go && !hit && at_end && whole_ok);
  rev_jump_c: cover property (step_go && hit && rev);
endmodule

// ==== core/elj_pkg.sv ====
// constants and register map of the effect loop/jump sequencer
// assumes a single 25 MHz clock and an Avalon-MM register master
//
// Overview of operation
// R1: whole effect loops, continuous capped 64000, or counted
// R2: earlier target: reaching source jumps back, span repeats
// R3: loop repeats forever or count; then run past
// R4: later target: reaching source skips forward, no loop
// R5: three independent jumps, each loop or skip
// R6: inner loop completes all repeats per outer pass
// R7: contained loop counter reloads when outer jumps back
// R8: overlapping loop counters keep exhausted state
// R9: reverse running swaps every jump source and target
// R10: each step compare time, decrement count, load target
package elj_pkg;
  localparam int TW = 16;
  localparam int NJ = 3;
  localparam logic [15:0] PASS_MAX = 16'hFA00;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_END = 8'h04;
  localparam logic [7:0] A_WCNT = 8'h08;
  localparam logic [7:0] A_TIME = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_JBASE = 8'h20;
  localparam logic [1:0] J_FROM = 2'h0;
  localparam logic [1:0] J_TO = 2'h1;
  localparam logic [1:0] J_CFG = 2'h2;
  localparam logic [1:0] J_REM = 2'h3;
  localparam int C_RUN = 0;
  localparam int C_REV = 1;
  localparam int C_WLOOP = 2;
  localparam int C_WCONT = 3;
  localparam int C_START = 4;
  localparam int G_EN = 16;
  localparam int G_CONT = 17;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [15:0] TIME_RST = 16'h0000;
endpackage

// ==== dv/tb_top.sv ====
// self-checking bench for elj_seq: register rows, then timeline walks
// assumes one wait cycle per bus access and about three cycles from step edge to time
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
  $display("FAIL t=%0t got %h exp %h", $time, a, e); end end
module tb_top;
  logic i_clk;
  logic i_rst_n;
  logic i_step;
  logic i_read;
  logic i_write;
  logic [7:0] i_address;
  logic [31:0] i_writedata;
  logic [31:0] o_readdata;
  logic [31:0] rd;
  logic o_waitrequest;
  logic o_done;
  logic [15:0] o_time;
  int err_total = 0;
  int samples_checked = 0;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} elj_row_s;
  elj_row_s rows [9];
  logic [31:0] nj [9] = '{default: 32'h0};

  elj_seq u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_step(i_step), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .o_time(o_time), .o_done(o_done));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // holds the request until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= d;
    i_write <= w;
    i_read <= ~w;
    do begin
      @(posedge i_clk);
    end while (o_waitrequest !== 1'b0);
    rd = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask

  // step pulse is long enough to pass the two-flop synchroniser
  task automatic step_once();
    @(posedge i_clk);
    i_step <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_step <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask

  // each character is the expected time after one step
  task automatic walk(input string s);
    for (int i = 0; i < s.len(); i++) begin
      step_once();
      `CHK(o_time, {8'h00, s[i] - 8'h30})
    end
  endtask

  task automatic prog(input logic [15:0] e, input logic [31:0] j [9], input logic [31:0] c);
    bus(1'b1, elj_pkg::A_END, {16'h0000, e});
    for (int k = 0; k < 9; k++) begin
      bus(1'b1, elj_pkg::A_JBASE + 8'(16 * (k / 3) + 4 * (k % 3)), j[k]);
    end
    bus(1'b1, elj_pkg::A_CTRL, c);
  endtask

  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #(40 * 40000);
    err_total++;
    test_done();
  end

  initial begin
    i_rst_n = 1'b0;
    i_step = 1'b0;
    i_read = 1'b0;
    i_write = 1'b0;
    i_address = 8'h00;
    i_writedata = 32'h0;
    rows = '{'{8'h04, 32'hFFFF1234, 32'h1234}, '{8'h08, 32'h3, 32'h3}, '{8'h00, 32'h1C, 32'hC},
      '{8'h20, 32'h5, 32'h5}, '{8'h34, 32'h7, 32'h7}, '{8'h48, 32'h3FFFF, 32'h3FFFF},
      '{8'h4C, 32'h0, 32'hFFFF}, '{8'h1C, 32'hFF, 32'h0}, '{8'h0C, 32'h9, 32'h0}};
    repeat (3) @(posedge i_clk);
    `CHK(o_time, 16'h0000)
    `CHK(o_waitrequest, 1'b1)
    `CHK(o_done, 1'b0)
    i_rst_n <= 1'b1;
    foreach (rows[r]) begin
      bus(1'b1, rows[r].a, rows[r].d);
      bus(1'b0, rows[r].a, 32'h0);
      `CHK(rd, rows[r].e)
    end
    prog(16'h6, '{32'h3, 32'h1, 32'h10002, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0}, 32'h11);
    @(posedge i_clk);
    `CHK(o_time, 16'h0000)
    walk("123123123456");
    step_once();
    `CHK(o_done, 1'b1)
    bus(1'b0, 8'h2C, 32'h0);
    `CHK(rd, 32'h0)
    prog(16'h7, '{32'h0, 32'h0, 32'h0, 32'h2, 32'h5, 32'h10000, 32'h6, 32'h5, 32'h10001}, 32'h11);
    walk("1256567");
    prog(16'h7, '{32'h6, 32'h1, 32'h10001, 32'h4, 32'h3, 32'h10001, 32'h0, 32'h0, 32'h0}, 32'h11);
    walk("12343456123434567");
    prog(16'h7, '{32'h4, 32'h2, 32'h10001, 32'h6, 32'h3, 32'h10001, 32'h0, 32'h0, 32'h0}, 32'h11);
    walk("12342345634567");
    prog(16'h5, '{32'h3, 32'h1, 32'h10001, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0}, 32'h13);
    @(posedge i_clk);
    `CHK(o_time, 16'h0005)
    walk("43213210");
    bus(1'b1, elj_pkg::A_WCNT, 32'h1);
    prog(16'h2, nj, 32'h15);
    walk("12012");
    step_once();
    bus(1'b0, elj_pkg::A_STAT, 32'h0);
    `CHK(rd, 32'h00010001)
    prog(16'h1, nj, 32'h1D);
    walk("10101");
    `CHK(o_done, 1'b0)
    // reset in mid-run must clear the timeline
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    `CHK(o_time, 16'h0000)
    i_rst_n <= 1'b1;
    repeat (2) begin
      @(posedge i_clk);
      `CHK(o_time, 16'h0000)
      `CHK(o_done, 1'b0)
      `CHK(o_waitrequest, 1'b1)
    end
    bus(1'b0, elj_pkg::A_STAT, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b0, elj_pkg::A_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    test_done();
  end
endmodule
